// file: sspc_ctrl.sv
// Control and status bits of the sync serial port, with a small host
// sequencer for Start/Repeated Start/Ack/Stop and the client-side byte flow.
// Assumes pins are open drain, sampled asynchronously, and software on Avalon-MM.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
module sspc_ctrl
	import sspc_pkg::*;
#(
	parameter int HALF_BIT_CYC = SSPC_HALF_BIT_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Avalon-MM slave
	input wire logic [13:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic [1:0] avs_response_o,
	// Bus pins
	input wire logic serial_clock_pin_i,
	output logic serial_clock_pin_o,
	output logic serial_clock_pin_oe_o,
	input wire logic serial_data_pin_i,
	output logic serial_data_pin_o,
	output logic serial_data_pin_oe_o,
	// Interrupt
	output logic irq_o
);
	import sspc_pkg::*;

	typedef struct packed {
		logic [1:0] scl_sync;
		logic [1:0] sda_sync;
		logic scl_q;
		logic sda_q;
		logic [7:0] con1;
		logic [7:0] con2;
		logic [7:0] con3;
		logic [7:0] buffer;
		logic buf_full;
		logic [7:0] shift;
		logic [3:0] bit_cnt;
		logic addr_phase;
		logic in_frame;
		logic [3:0] irq_stat;
		logic [3:0] irq_en;
		sspc_seq_type seq;
		logic [7:0] tmr;
		logic scl_drv_low;
		logic sda_drv_low;
		logic [4:0] hold_cnt;
		logic sda_pend;
		logic sda_want_low;
		logic ack_pending;
		logic ack_drive;
		logic [31:0] rdata;
		logic ack_done;
	} sspc_state_type;

	sspc_state_type st_ff;
	sspc_state_type nxt_st;

	function automatic logic is_spi(input logic [3:0] m);
		is_spi = (m <= 4'h5) || (m == 4'hA);
	endfunction

	function automatic logic is_host(input logic [3:0] m);
		is_host = (m == SSPC_MODE_I2C_HOST) || (m == SSPC_MODE_I2C_FW);
	endfunction

	logic [3:0] mode;
	logic spi_mode;
	logic host_mode;
	logic client_mode;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic sel;
	logic [11:0] idx;
	logic wr_lo;
	logic busy;
	logic byte_done;
	logic [7:0] rx_byte;
	logic [4:0] hold_len;

	assign mode = st_ff.con1[3:0];
	assign spi_mode = is_spi(mode);
	assign host_mode = is_host(mode);
	assign client_mode = !spi_mode && !host_mode;
	// Edges use only the second sync stage and its delayed copy
	assign scl_rise = st_ff.scl_sync[1] && !st_ff.scl_q;
	assign scl_fall = !st_ff.scl_sync[1] && st_ff.scl_q;
	assign start_det = st_ff.scl_sync[1] && st_ff.sda_q && !st_ff.sda_sync[1];
	assign stop_det = st_ff.scl_sync[1] && !st_ff.sda_q && st_ff.sda_sync[1];
	assign sel = avs_read_i || avs_write_i;
	assign idx = avs_address_i[13:2];
	assign wr_lo = avs_write_i && avs_byteenable_i[0];
	assign busy = st_ff.seq != SSPC_ST_IDLE;
	assign byte_done = scl_rise && (st_ff.bit_cnt == 4'd7);
	assign rx_byte = {st_ff.shift[6:0], st_ff.sda_sync[1]};
	assign hold_len = st_ff.con3[SSPC_C3_DATA_HOLD_TIME_SELECT] ? 5'(SSPC_HOLD_LONG_CYC) : 5'(SSPC_HOLD_SHORT_CYC);

	always_comb begin
		nxt_st = st_ff;
		nxt_st.scl_sync = {st_ff.scl_sync[0], serial_clock_pin_i};
		nxt_st.sda_sync = {st_ff.sda_sync[0], serial_data_pin_i};
		nxt_st.scl_q = st_ff.scl_sync[1];
		nxt_st.sda_q = st_ff.sda_sync[1];
		nxt_st.ack_done = 1'b0;

		// Bus condition events
		if (start_det) begin
			nxt_st.in_frame = 1'b1;
			nxt_st.addr_phase = 1'b1;
			nxt_st.bit_cnt = 4'd0;
			if (!spi_mode && mode != SSPC_MODE_C10_SS && mode != SSPC_MODE_C10 && st_ff.con3[SSPC_C3_START_IRQ_ENABLE]) begin
				nxt_st.irq_stat[SSPC_IRQ_START] = 1'b1;
			end
		end
		if (stop_det) begin
			nxt_st.in_frame = 1'b0;
			if (!spi_mode && mode != SSPC_MODE_C10_SS && mode != SSPC_MODE_C10 && st_ff.con3[SSPC_C3_PCIE]) begin
				nxt_st.irq_stat[SSPC_IRQ_STOP] = 1'b1;
			end
		end

		// Byte shifter on clock rising edges, ninth clock is the ack slot
		if (st_ff.in_frame && scl_rise && !start_det) begin
			if (st_ff.bit_cnt == 4'(SSPC_BITS_PER_BYTE)) begin
				nxt_st.bit_cnt = 4'd0;
				nxt_st.addr_phase = 1'b0;
				nxt_st.con3[SSPC_C3_ACK_TIME_STATUS] = 1'b0;
			end else begin
				nxt_st.shift = rx_byte;
				nxt_st.bit_cnt = st_ff.bit_cnt + 4'd1;
			end
		end
		if (st_ff.in_frame && byte_done && !host_mode) begin
			nxt_st.irq_stat[SSPC_IRQ_BYTE] = 1'b1;
			if (st_ff.buf_full) begin
				nxt_st.con1[SSPC_C1_OV] = 1'b1;
			end
			if (spi_mode) begin
				if (st_ff.con3[SSPC_C3_BUFFER_OVERWRITE_ENABLE] || !st_ff.buf_full) begin
					nxt_st.buffer = rx_byte;
					nxt_st.buf_full = 1'b1;
				end
			end else if (st_ff.con3[SSPC_C3_BUFFER_OVERWRITE_ENABLE] || !st_ff.con1[SSPC_C1_OV]) begin
				nxt_st.buffer = rx_byte;
				nxt_st.buf_full = 1'b1;
			end
		end
		// Eighth falling edge: ack slot opens
		if (st_ff.in_frame && scl_fall && st_ff.bit_cnt == 4'(SSPC_BITS_PER_BYTE) && client_mode) begin
			if (st_ff.con3[SSPC_C3_ADDRESS_HOLD_ENABLE] || st_ff.con3[SSPC_C3_DATA_HOLD_ENABLE]) begin
				nxt_st.con3[SSPC_C3_ACK_TIME_STATUS] = 1'b1;
			end
			if (st_ff.addr_phase && st_ff.con3[SSPC_C3_ADDRESS_HOLD_ENABLE]) begin
				nxt_st.con1[SSPC_C1_CKP] = 1'b0;
			end
			if (!st_ff.addr_phase && st_ff.con3[SSPC_C3_DATA_HOLD_ENABLE]) begin
				nxt_st.con1[SSPC_C1_CKP] = 1'b0;
			end
		end
		if (!client_mode) begin
			nxt_st.con3[SSPC_C3_ACK_TIME_STATUS] = 1'b0;
		end
		// Client collision: released data line read back low
		if (client_mode && st_ff.con3[SSPC_C3_CLIENT_COLLISION_DETECT_ENABLE] && scl_rise && !st_ff.sda_drv_low && st_ff.ack_drive
			&& !st_ff.sda_sync[1]) begin
			nxt_st.irq_stat[SSPC_IRQ_COLL] = 1'b1;
		end

		// Host sequencer
		if (st_ff.tmr != 8'd0) begin
			nxt_st.tmr = st_ff.tmr - 8'd1;
		end else begin
			case (st_ff.seq)
				SSPC_ST_IDLE: begin
				end
				SSPC_ST_START_A: begin
					nxt_st.sda_want_low = 1'b1;
					nxt_st.seq = SSPC_ST_START_B;
					nxt_st.tmr = 8'(HALF_BIT_CYC);
				end
				SSPC_ST_START_B: begin
					nxt_st.scl_drv_low = 1'b1;
					nxt_st.con2[SSPC_C2_SEN] = 1'b0;
					nxt_st.con2[SSPC_C2_REPEAT_START_REQUEST] = 1'b0;
					nxt_st.seq = SSPC_ST_IDLE;
				end
				SSPC_ST_RSTART_A: begin
					nxt_st.scl_drv_low = 1'b0;
					nxt_st.seq = SSPC_ST_START_A;
					nxt_st.tmr = 8'(HALF_BIT_CYC);
				end
				SSPC_ST_ACK_A: begin
					nxt_st.scl_drv_low = 1'b0;
					nxt_st.seq = SSPC_ST_ACK_B;
					nxt_st.tmr = 8'(HALF_BIT_CYC);
				end
				SSPC_ST_ACK_B: begin
					nxt_st.scl_drv_low = 1'b1;
					nxt_st.con2[SSPC_C2_ACKEN] = 1'b0;
					nxt_st.seq = SSPC_ST_IDLE;
				end
				SSPC_ST_STOP_A: begin
					nxt_st.scl_drv_low = 1'b0;
					nxt_st.seq = SSPC_ST_STOP_B;
					nxt_st.tmr = 8'(HALF_BIT_CYC);
				end
				SSPC_ST_STOP_B: begin
					nxt_st.sda_want_low = 1'b0;
					nxt_st.con2[SSPC_C2_PEN] = 1'b0;
					nxt_st.seq = SSPC_ST_IDLE;
				end
				default: nxt_st.seq = SSPC_ST_IDLE;
			endcase
		end

		// Data line change waits out the hold time after each clock fall
		if (scl_fall) begin
			nxt_st.hold_cnt = hold_len;
		end else if (st_ff.hold_cnt != 5'd0) begin
			nxt_st.hold_cnt = st_ff.hold_cnt - 5'd1;
		end
		if (!spi_mode && (st_ff.hold_cnt == 5'd0) && !scl_fall) begin
			nxt_st.sda_drv_low = st_ff.sda_want_low;
		end
		if (client_mode) begin
			nxt_st.ack_drive = st_ff.in_frame && st_ff.bit_cnt == 4'(SSPC_BITS_PER_BYTE);
			nxt_st.sda_want_low = st_ff.in_frame && st_ff.bit_cnt == 4'(SSPC_BITS_PER_BYTE);
		end

		// Register writes; waitrequest is low only on the second cycle so each access is one-shot
		if (wr_lo && !avs_waitrequest_o) begin
			case (idx)
				SSPC_IDX_BUF: begin
					// A byte landing in the same cycle keeps the buffer marked full
					if (!busy && !byte_done) begin
						nxt_st.buf_full = 1'b0;
					end
				end
				SSPC_IDX_CON1: begin
					nxt_st.con1 = avs_writedata_i[7:0];
					// Overflow raised in this very cycle wins over the software write
					if (st_ff.in_frame && byte_done && !host_mode && st_ff.buf_full) begin
						nxt_st.con1[SSPC_C1_OV] = 1'b1;
					end
				end
				SSPC_IDX_CON2: begin
					nxt_st.con2[7:5] = avs_writedata_i[7:5];
					nxt_st.con2[3] = avs_writedata_i[3];
					if (host_mode && !busy) begin
						if (avs_writedata_i[SSPC_C2_SEN]) begin
							nxt_st.con2[SSPC_C2_SEN] = 1'b1;
							nxt_st.seq = SSPC_ST_START_A;
							nxt_st.tmr = 8'(HALF_BIT_CYC);
						end else if (avs_writedata_i[SSPC_C2_REPEAT_START_REQUEST]) begin
							nxt_st.con2[SSPC_C2_REPEAT_START_REQUEST] = 1'b1;
							nxt_st.sda_want_low = 1'b0;
							nxt_st.seq = SSPC_ST_RSTART_A;
							nxt_st.tmr = 8'(HALF_BIT_CYC);
						end else if (avs_writedata_i[SSPC_C2_PEN]) begin
							nxt_st.con2[SSPC_C2_PEN] = 1'b1;
							nxt_st.sda_want_low = 1'b1;
							nxt_st.seq = SSPC_ST_STOP_A;
							nxt_st.tmr = 8'(HALF_BIT_CYC);
						end else if (avs_writedata_i[SSPC_C2_ACKEN]) begin
							nxt_st.con2[SSPC_C2_ACKEN] = 1'b1;
							nxt_st.sda_want_low = !avs_writedata_i[SSPC_C2_ACK_VALUE_TO_SEND];
							nxt_st.seq = SSPC_ST_ACK_A;
							nxt_st.tmr = 8'(HALF_BIT_CYC);
						end
					end
				end
				SSPC_IDX_CON3: nxt_st.con3[6:0] = avs_writedata_i[6:0];
				SSPC_IDX_IRQ_EN: nxt_st.irq_en = avs_writedata_i[3:0];
				SSPC_IDX_IRQ_CLR: begin
					// New events this cycle win over the clear
					nxt_st.irq_stat = (st_ff.irq_stat & ~avs_writedata_i[3:0]) | (nxt_st.irq_stat & ~st_ff.irq_stat);
				end
				default: begin
				end
			endcase
		end
		// Reading the buffer empties it
		if (avs_read_i && !avs_waitrequest_o && idx == SSPC_IDX_BUF && !byte_done) begin
			nxt_st.buf_full = 1'b0;
		end

		// Read data is captured once per access so it stands while the bus is idle
		if (sel && !st_ff.ack_pending) begin
			case (idx)
				SSPC_IDX_BUF: nxt_st.rdata = {24'h00_0000, st_ff.buffer};
				SSPC_IDX_CON1: nxt_st.rdata = {24'h00_0000, st_ff.con1};
				SSPC_IDX_CON2: nxt_st.rdata = {24'h00_0000, st_ff.con2};
				SSPC_IDX_CON3: nxt_st.rdata = {24'h00_0000, st_ff.con3};
				SSPC_IDX_IRQ_STAT: nxt_st.rdata = {28'h000_0000, st_ff.irq_stat};
				SSPC_IDX_IRQ_EN: nxt_st.rdata = {28'h000_0000, st_ff.irq_en};
				SSPC_IDX_STAT: nxt_st.rdata = {29'h0000_0000, busy, st_ff.in_frame, st_ff.buf_full};
				default: nxt_st.rdata = 32'h0000_0000;
			endcase
		end
		nxt_st.ack_pending = sel && !st_ff.ack_pending;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_ff <= '0;
			st_ff.scl_sync <= 2'b11;
			st_ff.sda_sync <= 2'b11;
			st_ff.scl_q <= 1'b1;
			st_ff.sda_q <= 1'b1;
			st_ff.con1 <= SSPC_RST_CON1;
			st_ff.con2 <= SSPC_RST_CON2;
			st_ff.con3 <= SSPC_RST_CON3;
			st_ff.seq <= SSPC_ST_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// One wait cycle, then answer with registered read data
	assign avs_waitrequest_o = sel && !st_ff.ack_pending;
	assign avs_readdata_o = st_ff.rdata;
	assign avs_response_o = 2'b00;
	// Open drain: only ever pull low
	assign serial_clock_pin_o = 1'b0;
	assign serial_clock_pin_oe_o = st_ff.scl_drv_low || (client_mode && st_ff.in_frame && !st_ff.con1[SSPC_C1_CKP]);
	assign serial_data_pin_o = 1'b0;
	assign serial_data_pin_oe_o = st_ff.sda_drv_low;
	assign irq_o = |(st_ff.irq_stat & st_ff.irq_en);
endmodule

// file: sspc_pkg.sv
// Package for the sync serial port control bits block.
// Assumes a single system clock domain and an Avalon-MM register slave.
package sspc_pkg;
	// Register indices (printed offsets are not multiples of four)
	localparam logic [11:0] SSPC_IDX_BUF = 12'h018C;
	localparam logic [11:0] SSPC_IDX_CON1 = 12'h0190;
	localparam logic [11:0] SSPC_IDX_CON2 = 12'h0191;
	localparam logic [11:0] SSPC_IDX_CON3 = 12'h0192;
	localparam logic [11:0] SSPC_IDX_IRQ_STAT = 12'h0193;
	localparam logic [11:0] SSPC_IDX_IRQ_EN = 12'h0194;
	localparam logic [11:0] SSPC_IDX_IRQ_CLR = 12'h0195;
	localparam logic [11:0] SSPC_IDX_STAT = 12'h0196;
	// Control register 1 fields
	localparam int SSPC_C1_OV = 6;
	localparam int SSPC_C1_CKP = 4;
	// Control register 2 fields
	localparam int SSPC_C2_ACK_VALUE_TO_SEND = 5;
	localparam int SSPC_C2_ACKEN = 4;
	localparam int SSPC_C2_PEN = 2;
	localparam int SSPC_C2_REPEAT_START_REQUEST = 1;
	localparam int SSPC_C2_SEN = 0;
	// Control register 3 fields
	localparam int SSPC_C3_ACK_TIME_STATUS = 7;
	localparam int SSPC_C3_PCIE = 6;
	localparam int SSPC_C3_START_IRQ_ENABLE = 5;
	localparam int SSPC_C3_BUFFER_OVERWRITE_ENABLE = 4;
	localparam int SSPC_C3_DATA_HOLD_TIME_SELECT = 3;
	localparam int SSPC_C3_CLIENT_COLLISION_DETECT_ENABLE = 2;
	localparam int SSPC_C3_ADDRESS_HOLD_ENABLE = 1;
	localparam int SSPC_C3_DATA_HOLD_ENABLE = 0;
	// Interrupt status bits
	localparam int SSPC_IRQ_START = 0;
	localparam int SSPC_IRQ_STOP = 1;
	localparam int SSPC_IRQ_BYTE = 2;
	localparam int SSPC_IRQ_COLL = 3;
	// Reset values
	localparam logic [7:0] SSPC_RST_CON1 = 8'h10;
	localparam logic [7:0] SSPC_RST_CON2 = 8'h00;
	localparam logic [7:0] SSPC_RST_CON3 = 8'h00;
	// Mode select codes
	localparam logic [3:0] SSPC_MODE_I2C_HOST = 4'h8;
	localparam logic [3:0] SSPC_MODE_I2C_FW = 4'hB;
	localparam logic [3:0] SSPC_MODE_C10_SS = 4'hF;
	localparam logic [3:0] SSPC_MODE_C10 = 4'h7;
	// Timing
	localparam int SSPC_CLK_MHZ = 50;
	localparam int SSPC_HOLD_LONG_NS = 300;
	localparam int SSPC_HOLD_SHORT_NS = 100;
	localparam int SSPC_HOLD_LONG_CYC = (SSPC_HOLD_LONG_NS * SSPC_CLK_MHZ + 999) / 1000;
	localparam int SSPC_HOLD_SHORT_CYC = (SSPC_HOLD_SHORT_NS * SSPC_CLK_MHZ + 999) / 1000;
	localparam int SSPC_HALF_BIT_CYC = 125;
	localparam int SSPC_BITS_PER_BYTE = 8;
	typedef enum logic [2:0] {
		SSPC_ST_IDLE,
		SSPC_ST_START_A,
		SSPC_ST_START_B,
		SSPC_ST_RSTART_A,
		SSPC_ST_ACK_A,
		SSPC_ST_ACK_B,
		SSPC_ST_STOP_A,
		SSPC_ST_STOP_B
	} sspc_seq_type;
endpackage

// file: sspc_chk.sv
// Checker for sspc_ctrl: bus handshake, pin and interrupt relations.
// Assumes it is bound into sspc_ctrl and sees only its ports.
module sspc_chk (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Avalon-MM
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic [1:0] avs_response_o,
	// Pins and interrupt
	input wire logic serial_clock_pin_i,
	input wire logic serial_clock_pin_o,
	input wire logic serial_clock_pin_oe_o,
	input wire logic serial_data_pin_i,
	input wire logic serial_data_pin_o,
	input wire logic serial_data_pin_oe_o,
	input wire logic irq_o
);
	// Cycles since a write or pin edge; an interrupt with no recent cause is a fault
	logic [7:0] quiet_ff;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			quiet_ff <= 8'h00;
		else if (avs_write_i || $changed(serial_clock_pin_i) || $changed(serial_data_pin_i))
			quiet_ff <= 8'h00;
		else if (quiet_ff != 8'hff)
			quiet_ff <= quiet_ff + 8'h01;
	end
	a_wait_one_cycle: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("waitrequest held too long");
	a_wait_first: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
		else $error("new request not stalled");
	a_resp_okay: assert property (avs_response_o == 2'b00)
		else $error("response not okay");
	a_rdata_stands: assert property (!avs_read_i && !avs_write_i |=> $stable(avs_readdata_o))
		else $error("read data moved while idle");
	a_reset_quiet: assert property ($past(rst_i) |-> !irq_o && !serial_clock_pin_oe_o && !serial_data_pin_oe_o)
		else $error("outputs active after reset");
	a_pin_open_drain: assert property (!serial_clock_pin_o && !serial_data_pin_o)
		else $error("pin driven high");
	a_irq_cause: assert property ($rose(irq_o) |-> quiet_ff < 8'h10)
		else $error("interrupt without cause");
	a_start_order: assert property ($rose(serial_clock_pin_oe_o) && serial_data_pin_oe_o |-> $past(serial_data_pin_oe_o))
		else $error("clock pulled before data");
endmodule
bind sspc_ctrl sspc_chk chk_u (.*);

// file: sspc_peer.sv
// Bus peer model: Start, bytes and Stop on open-drain lines, 160 ns clock period.
// Assumes pull-up wires outside; the peer only pulls low or lets go.
module sspc_peer (
	// Clock wire level
	input wire logic scl_w_i,
	// Pulls, high while the peer holds a line low
	output logic scl_pull_o,
	output logic sda_pull_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		scl_pull_o = 1'b0;
		sda_pull_o = 1'b0;
	end
	task automatic start_c();
		#7 sda_pull_o = 1'b1;
		#80 scl_pull_o = 1'b1;
		#40;
	endtask
	// Clock stands low between bits; a stretched clock delays the high phase
	task automatic bit_c(input logic b);
		sda_pull_o = !b;
		#40 scl_pull_o = 1'b0;
		for (int n = 0; n < 2000 && !scl_w_i; n++) #20;
		#80 scl_pull_o = 1'b1;
		#40;
	endtask
	task automatic byte_c(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) bit_c(b[i]);
		bit_c(1'b1);
	endtask
	task automatic stop_c();
		#7 sda_pull_o = 1'b1;
		#40 scl_pull_o = 1'b0;
		#80 sda_pull_o = 1'b0;
		#80;
	endtask
endmodule

// file: sspc_ctrl_test.sv
// Testbench for sspc_ctrl: registers, host sequences, client byte flow.
// Assumes the peer model and the checker bind; 50 MHz clock.
module sspc_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	import sspc_pkg::*;
	logic clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o, done;
	logic [13:0] avs_address_i;
	logic [3:0] avs_byteenable_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, d;
	logic [1:0] avs_response_o;
	logic serial_clock_pin_o, serial_clock_pin_oe_o, serial_data_pin_o, serial_data_pin_oe_o;
	logic scl_pull, sda_pull;
	int fail_count = 0;
	int comparisons = 0;
	// Pull-up wires: high unless a party pulls low
	wire serial_clock_pin_i = !(serial_clock_pin_oe_o || scl_pull);
	wire serial_data_pin_i = !(serial_data_pin_oe_o || sda_pull);
	sspc_ctrl #(.HALF_BIT_CYC(4)) dut_u (.*);
	sspc_peer peer_u (.scl_w_i(serial_clock_pin_i), .scl_pull_o(scl_pull), .sda_pull_o(sda_pull));
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	initial begin
		#300000;
		fail_count++;
		end_sim();
	end
	task automatic end_sim();
		if (fail_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One Avalon cycle; the request stands until waitrequest is seen low
	task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
		int n;
		@(posedge clk_i);
		avs_address_i <= {idx, 2'b00};
		avs_writedata_i <= {24'h00_0000, wd};
		avs_write_i <= wr;
		avs_read_i <= !wr;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 20);
		if (n >= 20) begin
			fail_count++;
			$display("unexpected at %0t: waitrequest %h expected %h", $time, avs_waitrequest_o, 1'b0);
		end
		if (!wr)
			d = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask
	task automatic poll(input logic [11:0] idx, input logic [7:0] mask, input logic [7:0] val);
		for (int n = 0; n < 200; n++) begin
			bus(1'b0, idx, 8'h00);
			if ((d[7:0] & mask) === val)
				break;
		end
		chk(d[7:0] & mask, val);
	endtask
	task automatic do_reset();
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask
	task automatic t_regs();
		bus(1'b0, SSPC_IDX_CON1, 8'h00);
		chk(d, SSPC_RST_CON1);
		bus(1'b0, SSPC_IDX_CON3, 8'h00);
		chk(d, SSPC_RST_CON3);
		bus(1'b0, 12'h0100, 8'h00);
		chk(d, 0);
		bus(1'b1, SSPC_IDX_IRQ_STAT, 8'h0f);
		bus(1'b0, SSPC_IDX_IRQ_STAT, 8'h00);
		chk(d, 0);
	endtask
	task automatic t_host();
		bus(1'b1, SSPC_IDX_CON1, {4'h1, SSPC_MODE_I2C_HOST});
		bus(1'b1, SSPC_IDX_CON2, 8'h01);
		bus(1'b1, SSPC_IDX_CON2, 8'h02);
		poll(SSPC_IDX_CON2, 8'h01, 8'h00);
		chk({serial_clock_pin_oe_o, serial_data_pin_oe_o}, 3);
		bus(1'b0, SSPC_IDX_CON2, 8'h00);
		chk(d, 0);
		bus(1'b1, SSPC_IDX_CON2, 8'h02);
		poll(SSPC_IDX_CON2, 8'h02, 8'h00);
		bus(1'b1, SSPC_IDX_CON2, 8'h30);
		for (int n = 0; n < 400 && serial_clock_pin_oe_o !== 1'b0; n++) @(posedge clk_i);
		chk(serial_clock_pin_oe_o, 0);
		chk(serial_data_pin_oe_o, 0);
		poll(SSPC_IDX_CON2, 8'h10, 8'h00);
		bus(1'b0, SSPC_IDX_CON3, 8'h00);
		chk(d[7], 0);
	endtask
	task automatic t_client_hold();
		bus(1'b1, SSPC_IDX_CON1, 8'h16);
		bus(1'b1, SSPC_IDX_CON3, 8'h62);
		bus(1'b1, SSPC_IDX_IRQ_EN, 8'h03);
		peer_u.start_c();
		repeat (5) @(posedge clk_i);
		chk(irq_o, 1);
		bus(1'b1, SSPC_IDX_IRQ_CLR, 8'h01);
		bus(1'b1, SSPC_IDX_IRQ_EN, 8'h02);
		chk(irq_o, 0);
		done = 1'b0;
		fork
			begin
				peer_u.byte_c(8'ha5);
				done = 1'b1;
			end
		join_none
		poll(SSPC_IDX_CON1, 8'h10, 8'h00);
		chk(serial_clock_pin_oe_o, 1);
		bus(1'b0, SSPC_IDX_CON3, 8'h00);
		chk(d[7], 1);
		bus(1'b1, SSPC_IDX_CON1, 8'h16);
		for (int n = 0; n < 500 && done !== 1'b1; n++) @(posedge clk_i);
		bus(1'b0, SSPC_IDX_CON3, 8'h00);
		chk(d[7], 0);
		bus(1'b0, SSPC_IDX_BUF, 8'h00);
		chk(d, 8'ha5);
		peer_u.stop_c();
		repeat (5) @(posedge clk_i);
		chk(irq_o, 1);
		bus(1'b1, SSPC_IDX_IRQ_CLR, 8'h03);
	endtask
	task automatic t_overflow();
		bus(1'b1, SSPC_IDX_CON3, 8'h10);
		peer_u.start_c();
		bus(1'b0, SSPC_IDX_IRQ_STAT, 8'h00);
		chk(d[0], 0);
		peer_u.byte_c(8'h11);
		peer_u.byte_c(8'h22);
		bus(1'b0, SSPC_IDX_CON1, 8'h00);
		chk(d[6], 1);
		bus(1'b0, SSPC_IDX_BUF, 8'h00);
		chk(d, 8'h22);
		bus(1'b0, SSPC_IDX_CON1, 8'h00);
		chk(d[6], 1);
		bus(1'b1, SSPC_IDX_CON3, 8'h00);
		peer_u.byte_c(8'h33);
		bus(1'b0, SSPC_IDX_BUF, 8'h00);
		chk(d, 8'h22);
		bus(1'b1, SSPC_IDX_CON1, 8'h16);
		bus(1'b0, SSPC_IDX_CON1, 8'h00);
		chk(d[6], 0);
		peer_u.stop_c();
		repeat (5) @(posedge clk_i);
		chk(irq_o, 0);
	endtask
	initial begin
		rst_i = 1'b1;
		avs_address_i = '0;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_byteenable_i = 4'hf;
		avs_writedata_i = '0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_host();
		do_reset();
		t_client_hold();
		t_overflow();
		end_sim();
	end
endmodule
